/* hdl/csb_core_sys.sv */
// Core system signals, system control registers and bus address phase.
// Assumes a plain register port from software on the same clock.
`default_nettype none
module csb_core_sys
  import csb_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  warm_reset_in,
  input  wire logic [5:0]            irq_in,
  input  wire logic                  nmi_in,
  input  wire logic [7:0]            revision_option_in,
  input  wire logic [1:0]            byte_enable_mode_in,
  input  wire logic                  address_ready_in,
  input  wire logic                  wake_in,
  input  wire logic [3:0]            reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  output logic [31:0]                reg_rdata_out,
  output logic                       reduced_power_out,
  output logic                       sleep_out,
  output logic                       timer_irq_out,
  output logic [32:0]                bus_address_out,
  output logic                       address_valid_out,
  output logic [7:0]                 byte_enable_out,
  output logic                       irq_out
);
  typedef enum logic [2:0] {
    CSB_IDLE  = 3'b001,
    CSB_PHASE = 3'b010,
    CSB_DONE  = 3'b100
  } csb_state_t;

  logic              nmi_prev;
  logic              warm_sync;
  logic              warm_prev;
  logic              soft_pulse;
  logic              nmi_pulse;
  logic [31:0]       status;
  logic [31:0]       count;
  logic [31:0]       compare;
  logic [5:0]        pending;
  logic              nmi_taken;
  logic              timer_match;
  logic              wr_compare;
  logic [3:0]        ev_stat;
  logic [3:0]        ev_en;
  logic [3:0]        ev_set;
  logic [15:0]       busreq;
  logic [32:0]       busadr;
  logic              start_req;
  logic [3:0]        beats_left;
  logic              phase_done;
  csb_state_t        state;
  logic [7:0]        be_next;
  logic [31:0]       next_rdata;

  // Interrupt, NMI and ready lines are core-clock inputs used as sampled;
  // a filter on them would swallow one-cycle pulses and delay the phase
  csb_sync3 u_warm (.clk_in(clk_in), .rst_in(rst_in),
                    .pin_in(warm_reset_in), .level_out(warm_sync));

  // Only a fresh rising level counts, so a held line fires once
  assign nmi_pulse  = nmi_in & ~nmi_prev;
  assign soft_pulse = warm_sync & ~warm_prev;
  assign wr_compare = reg_write_in && reg_addr_in == CSB_REG_COMPARE;
  assign timer_match = count == compare;
  assign start_req  = reg_write_in && reg_addr_in == CSB_REG_BUSREQ &&
                      state == CSB_IDLE;
  assign phase_done = state == CSB_PHASE && address_ready_in;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nmi_prev  <= 1'b0;
      warm_prev <= 1'b0;
    end
    else
    begin
      nmi_prev  <= nmi_in;
      warm_prev <= warm_sync;
    end
  end

  // Pending interrupt lines follow the pins level by level
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pending <= 6'h00;
    else
      pending <= irq_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      nmi_taken <= 1'b0;
    else if (soft_pulse)
      nmi_taken <= 1'b0;
    else if (nmi_pulse)
      nmi_taken <= 1'b1;
    else if (reg_write_in && reg_addr_in == CSB_REG_CAUSE)
      nmi_taken <= 1'b0;
  end

  // Status register; warm reset restores it like a hard reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      status <= CSB_STATUS_RST;
    else if (soft_pulse)
      status <= CSB_STATUS_RST;
    else if (reg_write_in && reg_addr_in == CSB_REG_STATUS)
      status <= reg_wdata_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reduced_power_out <= 1'b0;
    else
      reduced_power_out <= soft_pulse ? 1'b0 :
        (reg_write_in && reg_addr_in == CSB_REG_STATUS) ?
        reg_wdata_in[CSB_ST_RP_POS] : status[CSB_ST_RP_POS];
  end

  // Count keeps running across warm reset, as the free timer would
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count <= 32'h00000000;
    else if (reg_write_in && reg_addr_in == CSB_REG_COUNT)
      count <= reg_wdata_in;
    else
      count <= count + 32'h00000001;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      compare <= 32'hffffffff;
    else if (wr_compare)
      compare <= reg_wdata_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_irq_out <= 1'b0;
    else if (wr_compare)
      timer_irq_out <= 1'b0;
    else if (timer_match)
      timer_irq_out <= 1'b1;
  end

  // Sleep set by wait command, left on any wake, pending interrupt, NMI edge or warm reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sleep_out <= 1'b0;
    else if (soft_pulse || nmi_pulse || wake_in || (|pending))
      sleep_out <= 1'b0;
    else if (reg_write_in && reg_addr_in == CSB_REG_WAIT)
      sleep_out <= 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busreq <= 16'h0000;
      busadr <= 33'h000000000;
    end
    else
    begin
      if (start_req)
        busreq <= reg_wdata_in[15:0];
      if (reg_write_in && reg_addr_in == CSB_REG_BUSADR &&
          state == CSB_IDLE)
        busadr <= {1'b0, reg_wdata_in};
    end
  end

  csb_be_gen u_be (
    .mode_in   (byte_enable_mode_in),
    .offset_in (reg_wdata_in[2:0]),
    .size_in   (reg_wdata_in[5:4]),
    .burst_in  (reg_wdata_in[CSB_BR_BURST_POS]),
    .be_out    (be_next)
  );

  // Address phase: held until ready sampled, then closes next cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state      <= CSB_IDLE;
      beats_left <= 4'h0;
    end
    else if (soft_pulse)
    begin
      state      <= CSB_IDLE;
      beats_left <= 4'h0;
    end
    else
    begin
      case (state)
        CSB_IDLE:
          if (start_req)
          begin
            state      <= CSB_PHASE;
            beats_left <= reg_wdata_in[CSB_BR_BURST_POS] ?
                          reg_wdata_in[CSB_BR_LEN_POS +: 4] : 4'h0;
          end
        CSB_PHASE:
          if (address_ready_in)
          begin
            // Next beat starts at once, so no stale address shows as valid
            if (beats_left != 4'h0)
              beats_left <= beats_left - 4'h1;
            else
              state <= CSB_DONE;
          end
        CSB_DONE:
          state <= CSB_IDLE;
        default:
          state <= CSB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      address_valid_out <= 1'b0;
      bus_address_out   <= 33'h000000000;
      byte_enable_out   <= 8'h00;
    end
    else if (soft_pulse)
      address_valid_out <= 1'b0;
    else if (start_req)
    begin
      address_valid_out <= 1'b1;
      bus_address_out   <= busadr;
      byte_enable_out   <= be_next;
    end
    else if (phase_done && beats_left != 4'h0)
    begin
      address_valid_out <= 1'b1;
      bus_address_out   <= 33'(bus_address_out + 33'h1);
    end
    else if (phase_done)
      address_valid_out <= 1'b0;
  end

  assign ev_set = {phase_done, timer_match & ~timer_irq_out, soft_pulse,
                   nmi_pulse};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ev_stat <= 4'h0;
      ev_en   <= 4'h0;
    end
    else
    begin
      if (reg_write_in && reg_addr_in == CSB_REG_EVCLR)
        ev_stat <= (ev_stat & ~reg_wdata_in[3:0]) | ev_set;
      else
        ev_stat <= ev_stat | ev_set;
      if (reg_write_in && reg_addr_in == CSB_REG_EVEN)
        ev_en <= reg_wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(ev_stat & ev_en);
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_addr_in == CSB_REG_STATUS)
      next_rdata = status;
    else if (reg_addr_in == CSB_REG_IDENT)
      next_rdata = {revision_option_in, CSB_ID_LOW};
    else if (reg_addr_in == CSB_REG_COUNT)
      next_rdata = count;
    else if (reg_addr_in == CSB_REG_COMPARE)
      next_rdata = compare;
    else if (reg_addr_in == CSB_REG_CAUSE)
      next_rdata = {23'h000000, nmi_taken, 2'h0, pending};
    else if (reg_addr_in == CSB_REG_BUSREQ)
      next_rdata = {13'h0000, state, busreq};
    else if (reg_addr_in == CSB_REG_BUSADR)
      next_rdata = busadr[31:0];
    else if (reg_addr_in == CSB_REG_EVSTAT)
      next_rdata = {28'h0000000, ev_stat};
    else if (reg_addr_in == CSB_REG_EVEN)
      next_rdata = {28'h0000000, ev_en};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h00000000;
    else if (reg_read_in)
      reg_rdata_out <= next_rdata;
    else
      reg_rdata_out <= 32'h00000000;
  end
endmodule // csb_core_sys
`default_nettype wire

/* hdl/csb_pkg.sv */
// Constants shared by the core system-signal and bus address-phase block.
// Assumes one core clock; the warm reset pin arrives asynchronously.
`default_nettype none
package csb_pkg;
  localparam int CSB_NUM_IRQ    = 6;
  localparam int CSB_ADDR_HI    = 35;
  localparam int CSB_ADDR_LO    = 3;
  localparam int CSB_BE_W       = 8;
  localparam int CSB_REV_W      = 8;
  localparam int CSB_ID_W       = 32;
  // Lower identity bits; value is arbitrary
  localparam logic [23:0] CSB_ID_LOW = 24'h00a5c3;
  // Register offsets
  localparam logic [3:0] CSB_REG_STATUS  = 4'h0;
  localparam logic [3:0] CSB_REG_IDENT   = 4'h1;
  localparam logic [3:0] CSB_REG_COUNT   = 4'h2;
  localparam logic [3:0] CSB_REG_COMPARE = 4'h3;
  localparam logic [3:0] CSB_REG_CAUSE   = 4'h4;
  localparam logic [3:0] CSB_REG_WAIT    = 4'h5;
  localparam logic [3:0] CSB_REG_BUSREQ  = 4'h6;
  localparam logic [3:0] CSB_REG_BUSADR  = 4'h7;
  localparam logic [3:0] CSB_REG_EVSTAT  = 4'h8;
  localparam logic [3:0] CSB_REG_EVCLR   = 4'h9;
  localparam logic [3:0] CSB_REG_EVEN    = 4'ha;
  // Status register field positions
  localparam int CSB_ST_RP_POS  = 0;
  localparam logic [31:0] CSB_STATUS_RST = 32'h00000000;
  // Bus request fields
  localparam int CSB_BR_BURST_POS = 8;
  localparam int CSB_BR_LEN_POS   = 12;
  localparam logic [1:0] CSB_MODE_LS     = 2'h0;
  localparam logic [1:0] CSB_MODE_SIMPLE = 2'h1;
  // Event bit positions
  localparam int CSB_EV_NMI   = 0;
  localparam int CSB_EV_SOFT  = 1;
  localparam int CSB_EV_TIMER = 2;
  localparam int CSB_EV_ADDR  = 3;
  localparam int CSB_EV_W     = 4;
endpackage
`default_nettype wire

/* hdl/csb_sync3.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is unrelated to clk_in.
`default_nettype none
module csb_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change only counted when stages two and three agree
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      level_out <= RST_VAL;
    else if (s2 == s3)
      level_out <= s3;
  end
endmodule // csb_sync3
`default_nettype wire

/* hdl/csb_be_gen.sv */
// Byte-enable pattern generator for one address phase.
// Assumes a registered consumer; output is combinational.
`default_nettype none
module csb_be_gen
  import csb_pkg::*;
(
  input  wire logic [1:0] mode_in,
  input  wire logic [2:0] offset_in,
  input  wire logic [1:0] size_in,
  input  wire logic       burst_in,
  output logic [7:0]      be_out
);
  logic [7:0] mask;
  logic [2:0] aligned;

  always_comb
  begin
    mask    = 8'h00;
    aligned = offset_in;
    case (size_in)
      2'h0: mask = 8'h01;
      2'h1: mask = 8'h03;
      2'h2: mask = 8'h0f;
      default: mask = 8'hff;
    endcase
    if (mode_in == CSB_MODE_SIMPLE)
      aligned = offset_in & ~((3'h1 << size_in) - 3'h1);
    if (burst_in)
      be_out = 8'hff;
    else
      be_out = 8'((mask << aligned) & 8'hff);
  end
endmodule // csb_be_gen
`default_nettype wire

/* test/csb_props.sv */
// Port assertions for the core system block.
// Assumes a bind from the bench top file; one clock domain.
`default_nettype none
module csb_props
  import csb_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [5:0]  irq_in,
  input wire logic        nmi_in,
  input wire logic [7:0]  revision_option_in,
  input wire logic        address_ready_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        reduced_power_out,
  input wire logic        sleep_out,
  input wire logic        timer_irq_out,
  input wire logic [32:0] bus_address_out,
  input wire logic        address_valid_out,
  input wire logic [7:0]  byte_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic wr_req;
  assign wr_req = reg_write_in && reg_addr_in == CSB_REG_BUSREQ;

  ident_top_a: assert property (
    reg_read_in && reg_addr_in == CSB_REG_IDENT
    |=> reg_rdata_out[31:24] == $past(revision_option_in))
    else $error("identity top byte differs from option pins");
  rp_mirror_a: assert property (
    reg_write_in && reg_addr_in == CSB_REG_STATUS
    |-> ##2 reduced_power_out == $past(reg_wdata_in[0], 2))
    else $error("reduced power output does not follow status");
  timer_clear_a: assert property (
    reg_write_in && reg_addr_in == CSB_REG_COMPARE |=> !timer_irq_out)
    else $error("timer irq still high after compare write");
  sleep_on_a: assert property (
    reg_write_in && reg_addr_in == CSB_REG_WAIT && irq_in == 6'h00
    && !nmi_in |-> ##[1:2] sleep_out)
    else $error("sleep output missing after wait");
  phase_open_a: assert property (
    wr_req && !address_valid_out |=> address_valid_out)
    else $error("address valid missing after request");
  burst_all_a: assert property (
    wr_req && !address_valid_out && reg_wdata_in[CSB_BR_BURST_POS]
    |=> byte_enable_out == 8'hff)
    else $error("burst byte enables not all set");
  be_live_a: assert property (
    address_valid_out |-> byte_enable_out != 8'h00)
    else $error("no byte lane enabled in address phase");
  addr_hold_a: assert property (
    $past(address_valid_out) && !$past(address_ready_in)
    |-> address_valid_out && $stable(bus_address_out)
    && $stable(byte_enable_out))
    else $error("address phase changed without ready");
  phase_close_a: assert property (
    $fell(address_valid_out) |-> $past(address_ready_in))
    else $error("address phase closed without ready");

  cover property ($fell(address_valid_out));
  cover property ($rose(timer_irq_out));
  cover property ($rose(sleep_out));
endmodule // csb_props
`default_nettype wire

/* test/csb_bus_slave.sv */
// Bus slave model answering address phases with ready.
// Assumes address valid is a registered output of the core.
`default_nettype none
module csb_bus_slave (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       valid_in,
  output var  logic       ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // Ready stays up through a burst and falls once valid is seen low
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      wait_cnt <= 4'h0;
      ready_out <= 1'b0;
    end
    else if (!valid_in)
    begin
      wait_cnt <= 4'h0;
      ready_out <= 1'b0;
    end
    else if (wait_cnt == delay_in)
      ready_out <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
endmodule // csb_bus_slave
`default_nettype wire

/* test/test_csb_core_sys.sv */
// Self-checking bench for the core system block.
// Assumes csb_props and csb_bus_slave are compiled alongside.
`default_nettype none
module test_csb_core_sys;
  timeunit 1ns;
  timeprecision 1ps;
  import csb_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, warm_reset_in = 1'b0;
  logic        nmi_in = 1'b0, wake_in = 1'b0, address_ready_in;
  logic        reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic [5:0]  irq_in = 6'h00;
  logic [7:0]  revision_option_in = 8'h5a, byte_enable_out;
  logic [1:0]  byte_enable_mode_in = 2'h1;
  logic [3:0]  reg_addr_in = 4'h0, delay = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, rdata, reg_rdata_out;
  logic [32:0] bus_address_out;
  logic        reduced_power_out, sleep_out, timer_irq_out;
  logic        address_valid_out, irq_out;
  int          miscompares = 0, checks_done = 0;

  always #2 clk_in = ~clk_in;

  csb_core_sys csb_core_sys_inst (.clk_in, .rst_in, .warm_reset_in,
    .irq_in, .nmi_in, .revision_option_in, .byte_enable_mode_in,
    .address_ready_in, .wake_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .reduced_power_out,
    .sleep_out, .timer_irq_out, .bus_address_out, .address_valid_out,
    .byte_enable_out, .irq_out);
  csb_bus_slave csb_bus_slave_inst (.clk_in, .rst_in, .delay_in(delay),
    .valid_in(address_valid_out), .ready_out(address_ready_in));

  task automatic chk(input string what, input logic [32:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 rdata = reg_rdata_out;
  endtask
  // Warm reset passes a filtering synchroniser, so pins are held a while
  task automatic pin_pulse(input logic warm);
    @(posedge clk_in);
    if (warm)
      warm_reset_in <= 1'b1;
    else
      nmi_in <= 1'b1;
    cyc(6);
    @(posedge clk_in);
    warm_reset_in <= 1'b0;
    nmi_in <= 1'b0;
    cyc(8);
  endtask
  task automatic phase(input logic [1:0] m, input logic [2:0] off,
    input logic [1:0] sz, input logic bst, input logic [3:0] ext, dl,
    input logic [7:0] be);
    int n;
    logic [3:0] k;
    logic [32:0] base;
    n = 0;
    k = 4'h0;
    base = 33'h00abcde10;
    @(posedge clk_in);
    byte_enable_mode_in <= m;
    delay <= dl;
    wr(CSB_REG_BUSADR, base[31:0]);
    wr(CSB_REG_BUSREQ, {16'h0, ext, 3'h0, bst, 2'h0, sz, 1'h0, off});
    #1 chk("valid", address_valid_out, 1'b1);
    while (address_valid_out === 1'b1 && n < 200)
    begin
      if (bus_address_out !== base + k)
        k++;
      chk("addr", bus_address_out, base + k);
      chk("be", byte_enable_out, be);
      cyc(1);
      n++;
    end
    chk("beats", k, ext);
    chk("hold", n, 33'(dl) + 33'(ext) + 33'd2);
    rd(CSB_REG_EVSTAT);
    chk("phase_ev", rdata[CSB_EV_ADDR], 1'b1);
    wr(CSB_REG_EVCLR, 32'hf);
  endtask

  initial
  begin
    #40us;
    miscompares++;
    close_out;
  end

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    cyc(4);
    rd(CSB_REG_STATUS);
    chk("status", rdata, CSB_STATUS_RST);
    rd(4'hf);
    chk("unmapped", rdata, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_in);
      revision_option_in <= 8'h5a ^ {8{i[0]}};
      wr(CSB_REG_IDENT, 32'hffffffff);
      rd(CSB_REG_IDENT);
      chk("ident", rdata, {revision_option_in, CSB_ID_LOW});
    end
    for (int v = 1; v >= 0; v--)
    begin
      wr(CSB_REG_STATUS, 32'(v));
      cyc(2);
      chk("rp", reduced_power_out, 33'(v));
    end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_in);
      irq_in <= 6'h1 << i;
      cyc(6);
      rd(CSB_REG_CAUSE);
      chk("cause", rdata[5:0], 6'h1 << i);
    end
    @(posedge clk_in);
    irq_in <= 6'h00;
    wr(CSB_REG_EVEN, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(CSB_REG_EVEN, 32'h0);
      pin_pulse(1'b0);
      rd(CSB_REG_EVSTAT);
      chk("nmi_ev", rdata[CSB_EV_NMI], 1'b1);
      chk("irq", irq_out, i < 2);
      wr(CSB_REG_EVCLR, 32'h1);
      cyc(2);
      chk("irq_clr", irq_out, 1'b0);
    end
    rd(CSB_REG_CAUSE);
    chk("nmi_cause", rdata[8], 1'b1);
    wr(CSB_REG_CAUSE, 32'h0);
    rd(CSB_REG_CAUSE);
    chk("cause_clr", rdata[8], 1'b0);
    @(posedge clk_in);
    nmi_in <= 1'b1;
    @(posedge clk_in);
    nmi_in <= 1'b0;
    rd(CSB_REG_CAUSE);
    chk("nmi_short", rdata[8], 1'b1);
    wr(CSB_REG_WAIT, 32'h1);
    cyc(2);
    chk("sleep", sleep_out, 1'b1);
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    cyc(2);
    chk("wake", sleep_out, 1'b0);
    phase(2'h1, 3'h5, 2'h2, 1'b0, 4'h0, 4'h0, 8'hf0);
    phase(2'h0, 3'h5, 2'h0, 1'b0, 4'h0, 4'h5, 8'h20);
    phase(2'h1, 3'h3, 2'h1, 1'b0, 4'h0, 4'h2, 8'h0c);
    phase(2'h0, 3'h0, 2'h3, 1'b1, 4'h3, 4'h0, 8'hff);
    rd(CSB_REG_COUNT);
    wr(CSB_REG_COMPARE, rdata + 32'd40);
    cyc(2);
    chk("timer_early", timer_irq_out, 1'b0);
    cyc(50);
    chk("timer", timer_irq_out, 1'b1);
    wr(CSB_REG_COMPARE, 32'hffffffff);
    cyc(1);
    chk("timer_clr", timer_irq_out, 1'b0);
    wr(CSB_REG_STATUS, 32'h1);
    wr(CSB_REG_EVCLR, 32'hf);
    pin_pulse(1'b1);
    chk("warm_rp", reduced_power_out, 1'b0);
    rd(CSB_REG_EVSTAT);
    chk("warm_ev", rdata[CSB_EV_SOFT], 1'b1);
    close_out;
  end
endmodule // test_csb_core_sys

bind csb_core_sys csb_props csb_props_inst (.clk_in, .rst_in, .irq_in,
  .nmi_in, .revision_option_in, .address_ready_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
  .reduced_power_out, .sleep_out, .timer_irq_out, .bus_address_out,
  .address_valid_out, .byte_enable_out);
`default_nettype wire
